/* bench/dhp_far_end.sv */
// Far end of the handshake pins: DMA controller or disk peripheral.
// Assumes the bench sets what it drives; bit order end, req, ack, rd, wr, disk irq.
`timescale 1ns/1ns
module dhp_far_end (
    input wire [5:0] en,
    input wire [5:0] val,
    input wire [3:0] dev_oe,
    input wire [3:0] dev_out,
    output wire [5:0] pin
);
    // Released lines float to their pulls: end of transfer and strobes up, request and disk irq down
    localparam [5:0] PULL = 6'h1D;
    wire [5:0] doe = {1'b0, dev_oe, 1'b0};
    assign pin = (doe & {1'b0, dev_out, 1'b0}) | (en & ~doe & val) | (~doe & ~en & PULL);
endmodule

/* bench/dhp_pin_ctrl_asserts.sv */
// Port-level checks on the handshake pin controller.
// Bound into dhp_pin_ctrl; one clock domain.
`timescale 1ns/1ns
`include "dhp_map.vh"
module dhp_pin_ctrl_asserts #(
    parameter [15:0] RESET_CYCLES = 16'h0008
) (
    input wire clock,
    input wire rst_n,
    input wire reset_pin_n,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire dma_request_line_oe,
    input wire dma_acknowledge_line_oe,
    input wire dma_read_strobe_oe,
    input wire dma_write_strobe_oe,
    input wire in_reset
);
    wire [3:0] oe = {dma_write_strobe_oe, dma_read_strobe_oe, dma_acknowledge_line_oe, dma_request_line_oe};
    wire ctl_wr = reg_wr && reg_addr == `DHP_ADDR_CTRL && !in_reset;
    reg [15:0] hold_cnt;
    // Edges spent stretched after the pin let go
    always @(posedge clock) begin
        hold_cnt <= (!rst_n || !reset_pin_n || !in_reset) ? 16'h0000 : hold_cnt + 16'h0001;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n || !reset_pin_n);
    pin_reset_a: assert property (disable iff (!rst_n) !reset_pin_n |-> in_reset && oe == 4'h0)
        else $error("reset pin ignored");
    stretch_hold_a: assert property (hold_cnt <= RESET_CYCLES + 16'h0004)
        else $error("reset stretch too long");
    req_ack_a: assert property (!(oe[0] && oe[1]))
        else $error("request and acknowledge both driven");
    strobe_dir_a: assert property (oe[1] == oe[2] && oe[2] == oe[3])
        else $error("strobe directions differ");
    turn_ack_a: assert property ($rose(oe[1]) |-> !$past(oe[0]))
        else $error("no turnaround before acknowledge");
    turn_req_a: assert property ($rose(oe[0]) |-> !$past(oe[1]))
        else $error("no turnaround before request");
    target_dir_a: assert property (ctl_wr && reg_wdata[1:0] == 2'h0 ##1 !ctl_wr [*3] |=> oe == 4'h1)
        else $error("target directions wrong");
    init_dir_a: assert property (ctl_wr && reg_wdata[1:0] != 2'h0 ##1 !ctl_wr [*3] |=> oe == 4'hE)
        else $error("initiator directions wrong");
endmodule
bind dhp_pin_ctrl dhp_pin_ctrl_asserts #(.RESET_CYCLES(RESET_CYCLES)) u_chk (.clock(clock), .rst_n(rst_n),
    .reset_pin_n(reset_pin_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .in_reset(in_reset),
    .dma_request_line_oe(dma_request_line_oe), .dma_acknowledge_line_oe(dma_acknowledge_line_oe),
    .dma_read_strobe_oe(dma_read_strobe_oe), .dma_write_strobe_oe(dma_write_strobe_oe));

/* bench/dhp_pin_ctrl_test.sv */
// Self-checking bench for dhp_pin_ctrl with the far-end pin model.
// Assumes dhp_map.vh on the include path; reset stretch shortened.
`timescale 1ns/1ns
`include "dhp_map.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; $display("BAD %0t %h %h", $time, g, e); end end
module dhp_pin_ctrl_test;
    localparam [15:0] RC = 16'h0008;
    reg clock = 1'b0;
    reg rst_n = 1'b0;
    reg reset_pin_n = 1'b1;
    reg [3:0] reg_addr = 4'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [5:0] far_en = 6'h00;
    reg [5:0] far_val = 6'h00;
    wire [7:0] reg_rdata;
    wire [5:0] pin;
    wire [3:0] dev_oe;
    wire [3:0] dev_out;
    wire irq;
    wire in_reset;
    int failures = 0;
    int compares = 0;
    int i;
    reg [31:0] seed = 32'h000138AE;
    reg [7:0] c;
    reg [7:0] v;
    always #5 clock = ~clock;
    dhp_pin_ctrl #(.RESET_CYCLES(RC)) i_dut (.clock(clock), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .end_of_transfer_in(pin[0]), .dma_request_line_in(pin[1]), .dma_request_line_out(dev_out[0]),
        .dma_request_line_oe(dev_oe[0]), .dma_acknowledge_line_in(pin[2]), .dma_acknowledge_line_out(dev_out[1]),
        .dma_acknowledge_line_oe(dev_oe[1]), .dma_read_strobe_in(pin[3]), .dma_read_strobe_out(dev_out[2]),
        .dma_read_strobe_oe(dev_oe[2]), .dma_write_strobe_in(pin[4]), .dma_write_strobe_out(dev_out[3]),
        .dma_write_strobe_oe(dev_oe[3]), .disk_interrupt_input(pin[5]), .irq(irq), .in_reset(in_reset));
    dhp_far_end i_far (.en(far_en), .val(far_val), .dev_oe(dev_oe), .dev_out(dev_out), .pin(pin));
    function [31:0] xs(input [31:0] s);
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    function [3:0] exp_oe(input [1:0] m);
        exp_oe = (m == 2'h0) ? 4'h1 : 4'hE;
    endfunction
    task wr(input [3:0] a, input [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task rd(input [3:0] a, output [7:0] q);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    task summarize;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #50000;
        failures = failures + 1;
        summarize;
    end
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        for (i = 0; i < 40 && in_reset !== 1'b0; i++) @(posedge clock);
        rd(`DHP_ADDR_CTRL, v);
        `CHK(v, 8'h08)
        rd(4'hF, v);
        `CHK({v, dev_oe}, 12'h001)
        // All four modes, random polarity, drive and far-end traffic on inputs
        for (i = 0; i < 12; i++) begin
            seed = xs(seed);
            c = {1'b0, seed[6:3], 1'b0, i[1:0]};
            far_en <= {1'b0, ~exp_oe(c[1:0]), 1'b0} & seed[21:16];
            far_val <= seed[27:22];
            wr(`DHP_ADDR_CTRL, c);
            wr(`DHP_ADDR_DRIVE, {4'h0, seed[11:8]});
            repeat (8) @(posedge clock);
            `CHK(dev_oe, exp_oe(c[1:0]))
            `CHK(dev_out & dev_oe, ~(seed[11:8] ^ c[6:3]) & exp_oe(c[1:0]))
            rd(`DHP_ADDR_PINS, v);
            `CHK(v[7:1], {c[1:0], pin[5], ~(pin[4:1] ^ c[6:3])})
        end
        far_en <= 6'h20;
        far_val <= 6'h00;
        wr(`DHP_ADDR_CTRL, 8'h08);
        wr(`DHP_ADDR_IRQ_MASK, 8'h07);
        repeat (8) @(posedge clock);
        rd(`DHP_ADDR_IRQ_STAT, v);
        far_val <= 6'h20;
        repeat (8) @(posedge clock);
        `CHK(irq, 1'b1)
        rd(`DHP_ADDR_IRQ_STAT, v);
        `CHK(v, 8'h02)
        repeat (2) @(posedge clock);
        `CHK(irq, 1'b0)
        far_val <= 6'h00;
        wr(`DHP_ADDR_IRQ_MASK, 8'h00);
        repeat (4) @(posedge clock);
        far_val <= 6'h20;
        repeat (8) @(posedge clock);
        `CHK(irq, 1'b0)
        rd(`DHP_ADDR_IRQ_STAT, v);
        `CHK(v, 8'h02)
        // End of transfer in target mode also drops the request drive
        wr(`DHP_ADDR_DRIVE, 8'h01);
        far_en <= 6'h01;
        far_val <= 6'h00;
        repeat (8) @(posedge clock);
        rd(`DHP_ADDR_IRQ_STAT, v);
        `CHK(v, 8'h01)
        rd(`DHP_ADDR_DRIVE, v);
        `CHK(v, 8'h00)
        far_val <= 6'h01;
        wr(`DHP_ADDR_CTRL, 8'h09);
        rd(`DHP_ADDR_IRQ_STAT, v);
        far_val <= 6'h00;
        repeat (8) @(posedge clock);
        rd(`DHP_ADDR_IRQ_STAT, v);
        `CHK(v[0], 1'b0)
        // Pin reset between edges must act at once
        @(posedge clock);
        #3 reset_pin_n = 1'b0;
        #1 `CHK({in_reset, dev_oe}, 5'h10)
        @(posedge clock);
        reset_pin_n <= 1'b1;
        repeat (RC - 16'h0002) @(posedge clock);
        #1 `CHK(in_reset, 1'b1)
        for (i = 0; i < 8 && in_reset !== 1'b0; i++) @(posedge clock);
        rd(`DHP_ADDR_CTRL, v);
        `CHK({in_reset, v}, 9'h008)
        summarize;
    end
endmodule

/* hw/dhp_map.vh */
// Address map, field positions, reset values and timing of the
// DMA handshake pin controller.
// Assumes a register port with 4-bit word addresses and 8-bit data.
`ifndef DHP_MAP_VH
`define DHP_MAP_VH

// Register addresses
`define DHP_ADDR_CTRL 4'h0
`define DHP_ADDR_DRIVE 4'h1
`define DHP_ADDR_PINS 4'h2
`define DHP_ADDR_IRQ_STAT 4'h3
`define DHP_ADDR_IRQ_MASK 4'h4

// Control register fields
`define DHP_CTRL_INIT 0
`define DHP_CTRL_DISK 1
`define DHP_CTRL_POL_END 2
`define DHP_CTRL_POL_REQ 3
`define DHP_CTRL_POL_ACK 4
`define DHP_CTRL_POL_RD 5
`define DHP_CTRL_POL_WR 6
// Target mode, request active high, the rest active low
`define DHP_CTRL_RESET 8'h08

// Drive register fields: assert the matching pin while it is an output
`define DHP_DRV_REQ 0
`define DHP_DRV_ACK 1
`define DHP_DRV_RD 2
`define DHP_DRV_WR 3
`define DHP_DRIVE_RESET 8'h00

// Pin index, used in the sampled pin vector and the pins register
`define DHP_PIN_END 0
`define DHP_PIN_REQ 1
`define DHP_PIN_ACK 2
`define DHP_PIN_RD 3
`define DHP_PIN_WR 4
`define DHP_PIN_DISK_IRQ 5
`define DHP_PINS_INIT 6
`define DHP_PINS_DISK 7

// Interrupt status and mask fields
`define DHP_IRQ_END 0
`define DHP_IRQ_DISK 1
`define DHP_IRQ_REQ 2
`define DHP_IRQ_STAT_RESET 3'h0
`define DHP_IRQ_MASK_RESET 3'h0

// Reset pulse timing
`define DHP_RESET_PULSE_US 500
`define DHP_CLOCK_MHZ 100

`endif

/* hw/dhp_pin_ctrl.v */
// DMA handshake pin controller: direction, polarity and sampling of the
// request, acknowledge, read and write strobe pins, end-of-transfer and
// disk interrupt inputs, with a small register port and an interrupt.
// Assumes the pad ring resolves each two-way pin from _out and _oe.
//
// Contract
// - Reset pin low resets the device at once, without a clock edge; pulse 500 us.
// - End-of-transfer is sampled only in target mode, active level programmable.
// - Request pin is input when initiator bit is 1, device output when 0.
// - Acknowledge pin is input when initiator bit is 0, output when 1.
// - Read strobe pin is input when initiator bit is 0, output when 1.
// - Write strobe pin is input when initiator bit is 0, output when 1.
// - Disk interrupt input is taken as an interrupt request from the disk.
// - Pin directions also depend on the disk interface select bit.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "dhp_map.vh"

module dhp_pin_ctrl #(
    parameter [15:0] RESET_CYCLES = `DHP_RESET_PULSE_US * `DHP_CLOCK_MHZ
) (
    input wire clock,
    input wire rst_n,
    input wire reset_pin_n,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire end_of_transfer_in,
    input wire dma_request_line_in,
    output reg dma_request_line_out,
    output reg dma_request_line_oe,
    input wire dma_acknowledge_line_in,
    output reg dma_acknowledge_line_out,
    output reg dma_acknowledge_line_oe,
    input wire dma_read_strobe_in,
    output reg dma_read_strobe_out,
    output reg dma_read_strobe_oe,
    input wire dma_write_strobe_in,
    output reg dma_write_strobe_out,
    output reg dma_write_strobe_oe,
    input wire disk_interrupt_input,
    output reg irq,
    output reg in_reset
);

    // Reset stretch: the device stays in reset for the full pulse time
    // after the pin rises, so a short glitch still yields a clean reset.
    reg [15:0] hold_cnt_reg;
    wire run;

    assign run = (hold_cnt_reg == 16'h0000);

    always @(posedge clock or negedge reset_pin_n) begin
        if (!reset_pin_n) begin
            hold_cnt_reg <= RESET_CYCLES;
        end else if (!rst_n) begin
            hold_cnt_reg <= 16'h0000;
        end else if (!run) begin
            hold_cnt_reg <= hold_cnt_reg - 16'h0001;
        end
    end

    wire live;
    assign live = rst_n & run;

    // Pin sampling, three stages; a level is taken once stages two and
    // three agree, so a single metastable sample never counts.
    // Limitation: the reset pin itself is not synchronised on release.
    reg [5:0] s1_reg;
    reg [5:0] s2_reg;
    reg [5:0] s3_reg;
    reg [5:0] lvl_reg;
    wire [5:0] pins_raw;
    wire [5:0] lvl_next;

    assign pins_raw = {disk_interrupt_input, dma_write_strobe_in, dma_read_strobe_in,
                       dma_acknowledge_line_in, dma_request_line_in, end_of_transfer_in};
    assign lvl_next = (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));

    always @(posedge clock or negedge reset_pin_n) begin
        if (!reset_pin_n) begin
            s1_reg <= 6'h00;
            s2_reg <= 6'h00;
            s3_reg <= 6'h00;
            lvl_reg <= 6'h00;
        end else begin
            s1_reg <= pins_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end

    // Configuration
    reg [7:0] ctrl_reg;
    reg [7:0] drive_reg;
    reg [2:0] mask_reg;
    reg [2:0] stat_reg;
    reg [1:0] mode_reg;
    reg [5:0] act_prev_reg;

    wire init_sel;
    wire disk_sel;
    wire target;
    wire drive_strobes;
    wire drive_req;
    wire turn;
    wire [5:0] pol_vec;
    wire [5:0] act;

    assign init_sel = ctrl_reg[`DHP_CTRL_INIT];
    assign disk_sel = ctrl_reg[`DHP_CTRL_DISK];
    // Disk mode makes the device the strobing side whatever the initiator bit
    assign drive_strobes = init_sel | disk_sel;
    assign drive_req = ~init_sel & ~disk_sel;
    assign target = ~init_sel & ~disk_sel;
    assign turn = (mode_reg != {disk_sel, init_sel});

    // Interrupt request from the disk is fixed active high
    assign pol_vec = {1'b1, ctrl_reg[`DHP_CTRL_POL_WR], ctrl_reg[`DHP_CTRL_POL_RD],
                      ctrl_reg[`DHP_CTRL_POL_ACK], ctrl_reg[`DHP_CTRL_POL_REQ],
                      ctrl_reg[`DHP_CTRL_POL_END]};
    // Level normalised to asserted = 1
    assign act = lvl_reg ~^ pol_vec;

    // Events
    wire end_act;
    wire end_evt;
    wire disk_evt;
    wire req_evt;
    wire [2:0] evt;

    assign end_act = act[`DHP_PIN_END] & target;
    assign end_evt = end_act & ~act_prev_reg[`DHP_PIN_END];
    assign disk_evt = act[`DHP_PIN_DISK_IRQ] & ~act_prev_reg[`DHP_PIN_DISK_IRQ];
    assign req_evt = act[`DHP_PIN_REQ] & ~act_prev_reg[`DHP_PIN_REQ] & ~drive_req & ~turn;

    assign evt = 3'h0
        | ({2'h0, end_evt} << `DHP_IRQ_END)
        | ({2'h0, disk_evt} << `DHP_IRQ_DISK)
        | ({2'h0, req_evt} << `DHP_IRQ_REQ);

    wire stat_rd;
    wire [2:0] stat_next;

    assign stat_rd = reg_rd & (reg_addr == `DHP_ADDR_IRQ_STAT);
    // A new event beats the clear-on-read in the same cycle
    assign stat_next = (stat_reg & {3{~stat_rd}}) | evt;

    // Register writes
    always @(posedge clock or negedge reset_pin_n) begin
        if (!reset_pin_n) begin
            ctrl_reg <= `DHP_CTRL_RESET;
            drive_reg <= `DHP_DRIVE_RESET;
            mask_reg <= `DHP_IRQ_MASK_RESET;
        end else if (!live) begin
            ctrl_reg <= `DHP_CTRL_RESET;
            drive_reg <= `DHP_DRIVE_RESET;
            mask_reg <= `DHP_IRQ_MASK_RESET;
        end else begin
            if (reg_wr && reg_addr == `DHP_ADDR_CTRL) begin
                ctrl_reg <= reg_wdata;
            end
            if (reg_wr && reg_addr == `DHP_ADDR_DRIVE) begin
                drive_reg <= reg_wdata;
            end else if (end_evt) begin
                // End of transfer withdraws the device's own request
                drive_reg[`DHP_DRV_REQ] <= 1'b0;
            end
            if (reg_wr && reg_addr == `DHP_ADDR_IRQ_MASK) begin
                mask_reg <= reg_wdata[2:0];
            end
        end
    end

    // Status, edge history and interrupt line
    always @(posedge clock or negedge reset_pin_n) begin
        if (!reset_pin_n) begin
            stat_reg <= `DHP_IRQ_STAT_RESET;
            act_prev_reg <= 6'h00;
            irq <= 1'b0;
        end else if (!live) begin
            stat_reg <= `DHP_IRQ_STAT_RESET;
            // Track pin levels in reset so no false edge follows it
            act_prev_reg <= {act[5:1], end_act};
            irq <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            act_prev_reg <= {act[5:1], end_act};
            irq <= |(stat_next & mask_reg);
        end
    end

    // Pin drivers. A change of mode releases every pin for one cycle so
    // the two sides never drive a pin at once during the swap.
    wire req_oe_next;
    wire ack_oe_next;
    wire rd_oe_next;
    wire wr_oe_next;
    wire req_out_next;
    wire ack_out_next;
    wire rd_out_next;
    wire wr_out_next;

    assign req_oe_next = drive_req & ~turn;
    assign ack_oe_next = drive_strobes & ~turn;
    assign rd_oe_next = drive_strobes & ~turn;
    assign wr_oe_next = drive_strobes & ~turn;
    // Asserted drive shows the active level of the chosen polarity
    assign req_out_next = drive_reg[`DHP_DRV_REQ] ~^ ctrl_reg[`DHP_CTRL_POL_REQ];
    assign ack_out_next = drive_reg[`DHP_DRV_ACK] ~^ ctrl_reg[`DHP_CTRL_POL_ACK];
    assign rd_out_next = drive_reg[`DHP_DRV_RD] ~^ ctrl_reg[`DHP_CTRL_POL_RD];
    assign wr_out_next = drive_reg[`DHP_DRV_WR] ~^ ctrl_reg[`DHP_CTRL_POL_WR];

    // Mode history, used to spot a swap of directions
    always @(posedge clock or negedge reset_pin_n) begin
        if (!reset_pin_n) begin
            mode_reg <= 2'h0;
        end else if (!live) begin
            mode_reg <= 2'h0;
        end else begin
            mode_reg <= {disk_sel, init_sel};
        end
    end

    always @(posedge clock or negedge reset_pin_n) begin
        if (!reset_pin_n) begin
            dma_request_line_oe <= 1'b0;
            dma_acknowledge_line_oe <= 1'b0;
            dma_read_strobe_oe <= 1'b0;
            dma_write_strobe_oe <= 1'b0;
            dma_request_line_out <= 1'b0;
            dma_acknowledge_line_out <= 1'b0;
            dma_read_strobe_out <= 1'b0;
            dma_write_strobe_out <= 1'b0;
        end else if (!live) begin
            dma_request_line_oe <= 1'b0;
            dma_acknowledge_line_oe <= 1'b0;
            dma_read_strobe_oe <= 1'b0;
            dma_write_strobe_oe <= 1'b0;
            dma_request_line_out <= 1'b0;
            dma_acknowledge_line_out <= 1'b0;
            dma_read_strobe_out <= 1'b0;
            dma_write_strobe_out <= 1'b0;
        end else begin
            dma_request_line_oe <= req_oe_next;
            dma_acknowledge_line_oe <= ack_oe_next;
            dma_read_strobe_oe <= rd_oe_next;
            dma_write_strobe_oe <= wr_oe_next;
            dma_request_line_out <= req_out_next;
            dma_acknowledge_line_out <= ack_out_next;
            dma_read_strobe_out <= rd_out_next;
            dma_write_strobe_out <= wr_out_next;
        end
    end

    // Read port: data in the cycle after the strobe, zero otherwise
    reg [7:0] rd_mux;
    wire [7:0] rdata_next;

    // Zero outside the answer cycle keeps the bus quiet
    assign rdata_next = reg_rd ? rd_mux : 8'h00;

    always @* begin
        rd_mux = 8'h00;
        case (reg_addr)
            `DHP_ADDR_CTRL: begin
                rd_mux = ctrl_reg;
            end
            `DHP_ADDR_DRIVE: begin
                rd_mux = drive_reg;
            end
            `DHP_ADDR_PINS: begin
                rd_mux = {disk_sel, init_sel, act[5:1], end_act};
            end
            `DHP_ADDR_IRQ_STAT: begin
                rd_mux = {5'h00, stat_reg};
            end
            `DHP_ADDR_IRQ_MASK: begin
                rd_mux = {5'h00, mask_reg};
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    always @(posedge clock or negedge reset_pin_n) begin
        if (!reset_pin_n) begin
            reg_rdata <= 8'h00;
            in_reset <= 1'b1;
        end else if (!live) begin
            reg_rdata <= 8'h00;
            in_reset <= 1'b1;
        end else begin
            reg_rdata <= rdata_next;
            in_reset <= 1'b0;
        end
    end

endmodule
